// [design/qcpwm_consts.vh]
`ifndef QCPWM_CONSTS_VH
`define QCPWM_CONSTS_VH

// ----------------------------------------
// Field widths
// ----------------------------------------
`define QCPWM_AMPL_W        8
`define QCPWM_SCALE_W       8
`define QCPWM_DRIVER_OFF_TIME_W        4
`define QCPWM_TBL_W         2
`define QCPWM_OPT_W         2
`define QCPWM_HOLD_W        5

// ----------------------------------------
// Standstill option codes
// ----------------------------------------
`define QCPWM_OPT_NORMAL    2'h0
`define QCPWM_OPT_STANDSTILL_COIL_OPTION 2'h1
`define QCPWM_OPT_SHORT_LS  2'h2
`define QCPWM_OPT_SHORT_HS  2'h3

// ----------------------------------------
// Blank times in clock cycles per setting
// ----------------------------------------
`define QCPWM_BLANK_0       6'h10
`define QCPWM_BLANK_1       6'h18
`define QCPWM_BLANK_2       6'h24
`define QCPWM_BLANK_3       6'h36

// ----------------------------------------
// Reset values and blank counter width
// ----------------------------------------
`define QCPWM_SCALE_RST     8'h00
`define QCPWM_CNT_W         6

`endif

// [design/qcpwm_blank.v]
`include "qcpwm_consts.vh"

module qcpwm_blank (
  // Clock and reset
  input  wire                    core_clk_i,
  input  wire                    rstn_i,
  // Control
  input  wire [`QCPWM_TBL_W-1:0] blank_sel_i,
  input  wire                    switch_evt_i,
  // Status
  output wire                    blank_o
);

  reg  [`QCPWM_CNT_W-1:0] cnt_ff;
  reg  [`QCPWM_CNT_W-1:0] nxt_cnt;
  reg  [`QCPWM_CNT_W-1:0] len;

  // ----------------------------------------
  // Blank length decode
  // ----------------------------------------
  always @* begin
    case (blank_sel_i)
      2'h0:    len = `QCPWM_BLANK_0;
      2'h1:    len = `QCPWM_BLANK_1;
      2'h2:    len = `QCPWM_BLANK_2;
      default: len = `QCPWM_BLANK_3;
    endcase
  end

  // Restart on every bridge switch; counts down to zero
  always @* begin
    if (switch_evt_i) begin
      nxt_cnt = len;
    end else if (cnt_ff != {`QCPWM_CNT_W{1'b0}}) begin
      nxt_cnt = cnt_ff - 6'h01;
    end else begin
      nxt_cnt = cnt_ff;
    end
  end

  always @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt_ff <= {`QCPWM_CNT_W{1'b0}};
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

  assign blank_o = (cnt_ff != {`QCPWM_CNT_W{1'b0}});

endmodule

// [design/qcpwm_config.v]
`include "qcpwm_consts.vh"

module qcpwm_config #(
  // Field widths
  parameter AMPL_W  = `QCPWM_AMPL_W,
  parameter SCALE_W = `QCPWM_SCALE_W,
  parameter HOLD_W  = `QCPWM_HOLD_W,
  parameter DRIVER_OFF_TIME_W  = `QCPWM_DRIVER_OFF_TIME_W
) (
  // Clock and reset
  input  wire                      core_clk_i,
  input  wire                      rstn_i,
  // Configuration fields (same clock domain)
  input  wire [AMPL_W-1:0]         voltage_amplitude_offset_i,
  input  wire                      autoscale_en_i,
  input  wire                      symmetric_force_i,
  input  wire [`QCPWM_OPT_W-1:0]   standstill_coil_option_i,
  input  wire [HOLD_W-1:0]         hold_current_i,
  input  wire                      quiet_mode_en_i,
  input  wire [DRIVER_OFF_TIME_W-1:0]         driver_off_time_i,
  input  wire [`QCPWM_TBL_W-1:0]   comparator_blank_time_i,
  // Inputs from the regulation loop and bridge
  input  wire [SCALE_W-1:0]        reg_scale_i,
  input  wire                      standstill_i,
  input  wire                      switch_evt_i,
  // Outputs to the PWM core
  output wire [AMPL_W-1:0]         user_ampl_o,
  output wire [AMPL_W-1:0]         reentry_limit_o,
  output wire                      symmetric_pwm_o,
  // Outputs to the bridge
  output wire                      driver_en_o,
  output wire                      standstill_coil_option_o,
  output wire                      short_ls_o,
  output wire                      short_hs_o,
  output wire                      comp_blank_o,
  // Readback
  output wire [SCALE_W-1:0]        pwm_scale_o
);

  // ----------------------------------------
  // Local constants
  // ----------------------------------------
  localparam [AMPL_W-1:0]  AMPL_ZERO = {AMPL_W{1'b0}};
  localparam [HOLD_W-1:0]  HOLD_ZERO = {HOLD_W{1'b0}};
  localparam [DRIVER_OFF_TIME_W-1:0]  DRIVER_OFF_TIME_ZERO = {DRIVER_OFF_TIME_W{1'b0}};
  localparam [SCALE_W-1:0] SCALE_RST = `QCPWM_SCALE_RST;

  // ----------------------------------------
  // Registers and next values
  // ----------------------------------------
  // Amplitude routing
  reg  [AMPL_W-1:0]  user_ampl_ff;
  reg  [AMPL_W-1:0]  nxt_user_ampl;
  reg  [AMPL_W-1:0]  reentry_limit_ff;
  reg  [AMPL_W-1:0]  nxt_reentry_limit;
  // PWM shape and driver enable
  reg                symmetric_pwm_ff;
  reg                nxt_symmetric_pwm;
  reg                driver_en_ff;
  reg                nxt_driver_en;
  // Standstill coil handling
  reg                standstill_coil_option_ff;
  reg                nxt_standstill_coil_option;
  reg                short_ls_ff;
  reg                nxt_short_ls;
  reg                short_hs_ff;
  reg                nxt_short_hs;
  // Scaling readback
  reg  [SCALE_W-1:0] pwm_scale_ff;
  reg  [SCALE_W-1:0] nxt_pwm_scale;
  // Decoded conditions
  wire               driver_on;
  wire               hold_is_zero;
  wire               standstill_act;

  // ----------------------------------------
  // Decoded conditions
  // ----------------------------------------
  // Any nonzero off-time counts as enabled; the value itself is unused
  assign driver_on      = (driver_off_time_i != DRIVER_OFF_TIME_ZERO);
  assign hold_is_zero   = (hold_current_i == HOLD_ZERO);
  // Standstill option needs zero hold current, quiet mode and rest
  // Driver must be on too, so a disabled bridge never brakes
  assign standstill_act = standstill_i && quiet_mode_en_i &&
                          hold_is_zero && driver_on;

  // ----------------------------------------
  // Amplitude routing
  // ----------------------------------------
  // Offset goes to one user only, so the other sees zero
  always @* begin
    if (autoscale_en_i) begin
      nxt_user_ampl     = AMPL_ZERO;
      nxt_reentry_limit = voltage_amplitude_offset_i;
    end else begin
      nxt_user_ampl     = voltage_amplitude_offset_i;
      nxt_reentry_limit = AMPL_ZERO;
    end
  end

  // ----------------------------------------
  // PWM shape
  // ----------------------------------------
  // Straight copy; the PWM core decides how often it updates
  always @* begin
    nxt_symmetric_pwm = symmetric_force_i;
  end

  // ----------------------------------------
  // Driver enable
  // ----------------------------------------
  // Off-time zero keeps the whole bridge off
  always @* begin
    nxt_driver_en = driver_on;
  end

  // ----------------------------------------
  // Standstill coil option decode
  // ----------------------------------------
  // At most one brake or standstill_coil_option line is high at a time
  // Low-side short brakes harder than high-side short
  always @* begin
    nxt_standstill_coil_option = 1'b0;
    nxt_short_ls  = 1'b0;
    nxt_short_hs  = 1'b0;
    if (standstill_act) begin
      case (standstill_coil_option_i)
        `QCPWM_OPT_STANDSTILL_COIL_OPTION: begin
          nxt_standstill_coil_option = 1'b1;
        end
        `QCPWM_OPT_SHORT_LS: begin
          nxt_short_ls = 1'b1;
        end
        `QCPWM_OPT_SHORT_HS: begin
          nxt_short_hs = 1'b1;
        end
        default: begin
          nxt_standstill_coil_option = 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Scaling readback
  // ----------------------------------------
  // Held when another chopper runs, so software sees last value
  always @* begin
    if (quiet_mode_en_i) begin
      nxt_pwm_scale = reg_scale_i;
    end else begin
      nxt_pwm_scale = pwm_scale_ff;
    end
  end

  // ----------------------------------------
  // Register bank
  // ----------------------------------------
  // Amplitude fields
  always @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      user_ampl_ff     <= AMPL_ZERO;
      reentry_limit_ff <= AMPL_ZERO;
    end else begin
      user_ampl_ff     <= nxt_user_ampl;
      reentry_limit_ff <= nxt_reentry_limit;
    end
  end

  // PWM shape and driver enable; driver stays off through reset
  always @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      symmetric_pwm_ff <= 1'b0;
      driver_en_ff     <= 1'b0;
    end else begin
      symmetric_pwm_ff <= nxt_symmetric_pwm;
      driver_en_ff     <= nxt_driver_en;
    end
  end

  // Standstill lines; all low in reset so coils are left alone
  always @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      standstill_coil_option_ff <= 1'b0;
      short_ls_ff  <= 1'b0;
      short_hs_ff  <= 1'b0;
    end else begin
      standstill_coil_option_ff <= nxt_standstill_coil_option;
      short_ls_ff  <= nxt_short_ls;
      short_hs_ff  <= nxt_short_hs;
    end
  end

  // Readback register
  always @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pwm_scale_ff <= SCALE_RST;
    end else begin
      pwm_scale_ff <= nxt_pwm_scale;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // Every data output except comp_blank_o comes straight from a flip-flop
  assign user_ampl_o     = user_ampl_ff;
  assign reentry_limit_o = reentry_limit_ff;
  assign symmetric_pwm_o = symmetric_pwm_ff;
  assign driver_en_o     = driver_en_ff;
  assign standstill_coil_option_o     = standstill_coil_option_ff;
  assign short_ls_o      = short_ls_ff;
  assign short_hs_o      = short_hs_ff;
  assign pwm_scale_o     = pwm_scale_ff;

  // ----------------------------------------
  // Comparator blanking
  // ----------------------------------------
  // Restarted by each bridge switch, so ringing is not taken for current
  qcpwm_blank u_blank (
    .core_clk_i   (core_clk_i),
    .rstn_i       (rstn_i),
    .blank_sel_i  (comparator_blank_time_i),
    .switch_evt_i (switch_evt_i),
    .blank_o      (comp_blank_o)
  );

endmodule

// [bench/qcpwm_bridge_model.sv]
module qcpwm_bridge_model (
  input  wire logic       core_clk_i,
  input  wire logic       pulse_req_i,
  output logic            switch_evt_o,
  output logic [7:0]      reg_scale_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // Scale moves every cycle so a stuck readback shows up
  initial switch_evt_o = 1'b0;
  initial reg_scale_o = 8'h00;
  always @(posedge core_clk_i) begin
    switch_evt_o <= pulse_req_i;
    reg_scale_o  <= reg_scale_o + 8'h35;
  end
endmodule

// [bench/qcpwm_config_chk.sv]
module qcpwm_config_chk (
  // Clock and reset
  input wire       core_clk_i,
  input wire       rstn_i,
  // Configuration fields
  input wire [7:0] voltage_amplitude_offset_i,
  input wire       autoscale_en_i,
  input wire       symmetric_force_i,
  input wire [1:0] standstill_coil_option_i,
  input wire [4:0] hold_current_i,
  input wire       quiet_mode_en_i,
  input wire [3:0] driver_off_time_i,
  input wire [1:0] comparator_blank_time_i,
  // Regulation loop and bridge
  input wire [7:0] reg_scale_i,
  input wire       standstill_i,
  input wire       switch_evt_i,
  // Design outputs
  input wire [7:0] user_ampl_o,
  input wire [7:0] reentry_limit_o,
  input wire       symmetric_pwm_o,
  input wire       driver_en_o,
  input wire       standstill_coil_option_o,
  input wire       short_ls_o,
  input wire       short_hs_o,
  input wire       comp_blank_o,
  input wire [7:0] pwm_scale_o
);
  timeunit 1ns;
  timeprecision 1ns;
  wire       g  = standstill_i & quiet_mode_en_i & ~|hold_current_i & |driver_off_time_i;
  wire [2:0] st = {short_hs_o, short_ls_o, standstill_coil_option_o};
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);
  a_user_ampl: assert property ($past(rstn_i) |-> user_ampl_o ==
    ($past(autoscale_en_i) ? 8'h00 : $past(voltage_amplitude_offset_i))) else $error("ampl");
  a_reentry_lim: assert property ($past(rstn_i) |-> reentry_limit_o ==
    ($past(autoscale_en_i) ? $past(voltage_amplitude_offset_i) : 8'h00)) else $error("limit");
  a_sym_copy: assert property ($past(rstn_i) |->
    symmetric_pwm_o == $past(symmetric_force_i)) else $error("sym");
  a_drv_enable: assert property ($past(rstn_i) |->
    driver_en_o == |$past(driver_off_time_i)) else $error("enable");
  a_stand_gate: assert property (|st |-> $past(g)) else $error("gate");
  a_opt_decode: assert property ($past(rstn_i) && $past(g) |->
    st == 3'((4'h1 << $past(standstill_coil_option_i)) >> 1)) else $error("option");
  a_scale_track: assert property ($past(rstn_i) && $past(quiet_mode_en_i) |->
    pwm_scale_o == $past(reg_scale_i)) else $error("track");
  a_scale_hold: assert property ($past(rstn_i) && !$past(quiet_mode_en_i) |->
    $stable(pwm_scale_o)) else $error("frozen");
  a_blank_len: assert property (switch_evt_i && comparator_blank_time_i == 2'h0 |=>
    comp_blank_o ##15 comp_blank_o ##1 !comp_blank_o) else $error("blank");
  a_blank_long: assert property (switch_evt_i && comparator_blank_time_i == 2'h3 |=>
    comp_blank_o ##53 comp_blank_o ##1 !comp_blank_o) else $error("blank long");
endmodule

// [bench/qcpwm_config_bench.sv]
module qcpwm_config_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rstn_i = 0, asc = 0, sym = 0, qm = 0, stand = 0, preq = 0;
  logic [7:0] ampl = 8'h00, s;
  logic [4:0] hold = 5'h00;
  logic [3:0] driver_off_time = 4'h0;
  logic [1:0] opt = 2'h0, comparator_blank_time = 2'h0;
  wire [7:0] rs, ua, rl, ps;
  wire evt, so, de, fw, ls, hs, cb;
  int n_mismatch = 0, samples_checked = 0, i, n;
  // Blank lengths per setting, in clock cycles
  logic [7:0] blank_exp [4] = '{8'h10, 8'h18, 8'h24, 8'h36};
  always #25 clk = ~clk;
  qcpwm_bridge_model bm (.core_clk_i(clk), .pulse_req_i(preq), .switch_evt_o(evt),
    .reg_scale_o(rs));
  qcpwm_config dut (.core_clk_i(clk), .rstn_i(rstn_i), .voltage_amplitude_offset_i(ampl),
    .autoscale_en_i(asc), .symmetric_force_i(sym), .standstill_coil_option_i(opt),
    .hold_current_i(hold), .quiet_mode_en_i(qm), .driver_off_time_i(driver_off_time),
    .comparator_blank_time_i(comparator_blank_time), .reg_scale_i(rs), .standstill_i(stand),
    .switch_evt_i(evt), .user_ampl_o(ua), .reentry_limit_o(rl), .symmetric_pwm_o(so),
    .driver_en_o(de), .standstill_coil_option_o(fw), .short_ls_o(ls), .short_hs_o(hs),
    .comp_blank_o(cb), .pwm_scale_o(ps));
  // Let the sampling edge pass, then look at settled outputs
  task step;
    @(posedge clk);
    @(negedge clk);
  endtask
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task test_done;
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // Inputs change by non-blocking assignment at a rising edge only
  initial begin
    repeat (6) @(posedge clk);
    rstn_i <= 1'b1;
    ampl <= 8'hff;
    sym <= 1'b1;
    step;
    chk(ua, 8'hff);
    chk(rl, 8'h00);
    chk({7'h0, so}, 8'h01);
    chk({7'h0, de}, 8'h00);
    @(posedge clk);
    asc <= 1'b1;
    sym <= 1'b0;
    driver_off_time <= 4'hf;
    qm <= 1'b1;
    stand <= 1'b1;
    step;
    chk(rl, 8'hff);
    chk(ua, 8'h00);
    chk({6'h0, so, de}, 8'h01);
    $display("field test done");
    // Every option code with the gate open, then the hold, quiet mode and standstill terms closed in turn
    for (i = 0; i < 4; i++) begin
      @(posedge clk);
      opt <= i[1:0];
      step;
      chk({5'h0, hs, ls, fw}, 8'((4'h1 << i) >> 1));
    end
    @(posedge clk);
    hold <= 5'h01;
    step;
    chk({5'h0, hs, ls, fw}, 8'h00);
    @(posedge clk);
    hold <= 5'h00;
    qm <= 1'b0;
    step;
    chk({5'h0, hs, ls, fw}, 8'h00);
    @(posedge clk);
    qm <= 1'b1;
    stand <= 1'b0;
    step;
    chk({5'h0, hs, ls, fw}, 8'h00);
    @(posedge clk);
    stand <= 1'b1;
    step;
    chk({5'h0, hs, ls, fw}, 8'h04);
    $display("standstill test done");
    step;
    s = rs;
    @(negedge clk);
    chk(ps, s);
    @(posedge clk);
    qm <= 1'b0;
    step;
    s = ps;
    repeat (3) @(negedge clk);
    chk(ps, s);
    $display("readback test done");
    // One switch pulse per blank setting, blank cycles counted at negedges
    for (i = 0; i < 4; i++) begin
      @(posedge clk);
      comparator_blank_time <= i[1:0];
      preq <= 1'b1;
      @(posedge clk);
      preq <= 1'b0;
      n = 0;
      repeat (70) begin
        @(negedge clk);
        if (cb === 1'b1) n++;
      end
      chk(8'(n), blank_exp[i]);
    end
    $display("blank test done");
    // Mid-run reset clears outputs, then fields take effect again
    @(posedge clk);
    rstn_i <= 1'b0;
    @(negedge clk);
    chk(rl, 8'h00);
    chk(ps, 8'h00);
    chk({6'h0, so, de}, 8'h00);
    repeat (2) @(posedge clk);
    rstn_i <= 1'b1;
    step;
    chk(rl, 8'hff);
    chk({6'h0, so, de}, 8'h01);
    $display("reset test done");
    test_done;
  end
endmodule
bind qcpwm_config qcpwm_config_chk u_chk (
  .core_clk_i                 (core_clk_i),
  .rstn_i                     (rstn_i),
  .voltage_amplitude_offset_i (voltage_amplitude_offset_i),
  .autoscale_en_i             (autoscale_en_i),
  .symmetric_force_i          (symmetric_force_i),
  .standstill_coil_option_i   (standstill_coil_option_i),
  .hold_current_i             (hold_current_i),
  .quiet_mode_en_i            (quiet_mode_en_i),
  .driver_off_time_i          (driver_off_time_i),
  .comparator_blank_time_i    (comparator_blank_time_i),
  .reg_scale_i                (reg_scale_i),
  .standstill_i               (standstill_i),
  .switch_evt_i               (switch_evt_i),
  .user_ampl_o                (user_ampl_o),
  .reentry_limit_o            (reentry_limit_o),
  .symmetric_pwm_o            (symmetric_pwm_o),
  .driver_en_o                (driver_en_o),
  .standstill_coil_option_o                (standstill_coil_option_o),
  .short_ls_o                 (short_ls_o),
  .short_hs_o                 (short_hs_o),
  .comp_blank_o               (comp_blank_o),
  .pwm_scale_o                (pwm_scale_o)
);
